// [src/gpio_port.sv]
// Top of the general-purpose I/O port: registers, pin drive, pull-up control
`timescale 1ns/1ps
// Function
// - The port has output latch, direction and pin sample registers; the sample is read-only.
// - Writing one to a pin sample bit inverts that latch bit; zero leaves it alone.
// - The global pull-up disable turns off every pull-up regardless of other bits.
// - Direction one makes a pin an output, zero an input.
// - An input pulls up only with latch one and pull-up disable zero, else floats.
// - An output drives its latch value and never pulls up.
// - Reset floats all pins asynchronously, with no clock needed.
// - The pin sample always shows the synchronised pin level in either direction.
// - Pins pass a clock-high latch and a rising-edge register, half to one and a half periods.
// - A level written through the latch shows in the sample one period later.
// - Direction and latch bits can be set or cleared singly without touching others.
module gpio_port
	import gpio_port_pkg::*;
#(
	parameter int WIDTH = PORT_WIDTH
)
(
	// Clock, enable and reset
	input wire logic i_clk,
	input wire logic i_ce,
	input wire logic i_rst_n,
	// Register access port
	input wire reg_req_t i_req,
	output logic [WIDTH-1:0] o_rdata,
	// Pins, as input, output value, output enable and pull-up enable
	input wire logic [WIDTH-1:0] i_pin,
	output logic [WIDTH-1:0] o_pin,
	output logic [WIDTH-1:0] o_pin_oe,
	output logic [WIDTH-1:0] o_pullup_en
);
	// ----------------------------------------------------------------
	// Register state
	// ----------------------------------------------------------------
	logic [WIDTH-1:0] latch_reg, latch_next;
	logic [WIDTH-1:0] dir_reg, dir_next;
	logic pullup_off_reg, pullup_off_next;
	logic [WIDTH-1:0] rdata_reg, rdata_next;
	logic [WIDTH-1:0] pin_reg, pin_next;
	logic [WIDTH-1:0] oe_reg, oe_next;
	logic [WIDTH-1:0] pu_reg, pu_next;
	logic [WIDTH-1:0] sample;

	// Applies write, set-bit or clear-bit to one register value
	function automatic logic [WIDTH-1:0] apply_op(input logic [WIDTH-1:0] cur,
		input reg_req_t req);
		logic [WIDTH-1:0] mask;
		mask = '0;
		mask[req.bit_idx] = 1'b1;
		case (req.op)
			OP_WRITE: apply_op = WIDTH'(req.wdata);
			OP_SET_BIT: apply_op = cur | mask;
			OP_CLEAR_BIT: apply_op = cur & ~mask;
			default: apply_op = cur;
		endcase
	endfunction

	// ----------------------------------------------------------------
	// Input synchroniser
	// ----------------------------------------------------------------
	gpio_sync #(.WIDTH(WIDTH)) u_sync (
		.i_clk(i_clk),
		.i_ce(i_ce),
		.i_rst_n(i_rst_n),
		.i_pins(i_pin),
		.o_sample(sample)
	);

	// Register writes; a one written to the sample address flips the latch
	always_comb
	begin
		logic [WIDTH-1:0] tog;
		tog = '0;
		latch_next = latch_reg;
		dir_next = dir_reg;
		pullup_off_next = pullup_off_reg;
		if (i_req.valid)
		begin
			if (i_req.sel == SEL_OUTPUT_LATCH)
				latch_next = apply_op(latch_reg, i_req);
			else if (i_req.sel == SEL_DIRECTION)
				dir_next = apply_op(dir_reg, i_req);
			else if (i_req.sel == SEL_PIN_SAMPLE)
			begin
				tog = apply_op('0, i_req);
				latch_next = latch_reg ^ tog;
			end
			else if (i_req.sel == SEL_CORE_CONTROL)
			begin
				if (i_req.op == OP_WRITE)
					pullup_off_next = i_req.wdata[PULLUP_DISABLE_BIT];
				else if (i_req.op == OP_SET_BIT && i_req.bit_idx == 3'(PULLUP_DISABLE_BIT))
					pullup_off_next = 1'b1;
				else if (i_req.op == OP_CLEAR_BIT && i_req.bit_idx == 3'(PULLUP_DISABLE_BIT))
					pullup_off_next = 1'b0;
			end
		end
	end

	// Pin drive, decided per pin so other pins are never disturbed
	always_comb
	begin
		oe_next = dir_next;
		pin_next = latch_next & dir_next;
		pu_next = ~dir_next & latch_next & {WIDTH{~pullup_off_next}};
	end

	// Read data mux; reserved control bits read zero
	always_comb
	begin
		rdata_next = '0;
		if (i_req.sel == SEL_OUTPUT_LATCH)
			rdata_next = latch_reg;
		else if (i_req.sel == SEL_DIRECTION)
			rdata_next = dir_reg;
		else if (i_req.sel == SEL_PIN_SAMPLE)
			rdata_next = sample;
		else
			rdata_next[PULLUP_DISABLE_BIT] = pullup_off_reg;
	end

	// ----------------------------------------------------------------
	// Registers; drive outputs registered so reset floats pins at once
	// ----------------------------------------------------------------
	always_ff @(posedge i_clk or negedge i_rst_n)
	begin
		if (!i_rst_n)
		begin
			latch_reg <= OUTPUT_LATCH_RESET;
			dir_reg <= DIRECTION_RESET;
			pullup_off_reg <= PULLUP_DISABLE_RESET;
			rdata_reg <= '0;
			pin_reg <= '0;
			oe_reg <= '0;
			pu_reg <= '0;
		end
		else if (i_ce)
		begin
			latch_reg <= latch_next;
			dir_reg <= dir_next;
			pullup_off_reg <= pullup_off_next;
			rdata_reg <= rdata_next;
			pin_reg <= pin_next;
			oe_reg <= oe_next;
			pu_reg <= pu_next;
		end
	end

	assign o_rdata = rdata_reg;
	assign o_pin = pin_reg;
	assign o_pin_oe = oe_reg;
	assign o_pullup_en = pu_reg;

	// ----------------------------------------------------------------
	// Assertions
	// ----------------------------------------------------------------
	sequence toggle_write_s;
		i_ce && i_req.valid && i_req.sel == SEL_PIN_SAMPLE && i_req.op == OP_WRITE;
	endsequence

	AST_TOGGLE: assert property (@(posedge i_clk) disable iff (!i_rst_n)
		toggle_write_s |=> latch_reg == ($past(latch_reg) ^ $past(i_req.wdata)))
		else $error("latch did not toggle by written ones");
	// Disable bit and pull-up outputs load at the same edge, so check in the same cycle
	AST_PULLUP_OFF: assert property (@(posedge i_clk) disable iff (!i_rst_n)
		pullup_off_reg |-> o_pullup_en == '0)
		else $error("pull-up active while globally disabled");
	AST_DIR: assert property (@(posedge i_clk) disable iff (!i_rst_n)
		i_ce |=> o_pin_oe == $past(dir_next))
		else $error("output enable does not follow direction");
	AST_PULLUP: assert property (@(posedge i_clk) disable iff (!i_rst_n)
		o_pullup_en == (~dir_reg & latch_reg & {WIDTH{~pullup_off_reg}}))
		else $error("pull-up does not match latch and direction");
	AST_DRIVE: assert property (@(posedge i_clk) disable iff (!i_rst_n)
		(o_pin_oe & (o_pin ^ latch_reg)) == '0 && (o_pin_oe & o_pullup_en) == '0)
		else $error("output pin level or pull-up wrong");
	AST_RESET: assert property (@(posedge i_clk)
		!i_rst_n |-> o_pin_oe == '0 && o_pullup_en == '0)
		else $error("pins not floating in reset");
	AST_SAMPLE: assert property (@(posedge i_clk) disable iff (!i_rst_n)
		i_ce && i_req.sel == SEL_PIN_SAMPLE |=> o_rdata == $past(sample))
		else $error("sample read wrong");
	AST_SETBIT: assert property (@(posedge i_clk) disable iff (!i_rst_n)
		i_ce && i_req.valid && i_req.sel == SEL_DIRECTION && i_req.op == OP_SET_BIT
		|=> dir_reg == ($past(dir_reg) | (WIDTH'(1) << $past(i_req.bit_idx))))
		else $error("single-bit set disturbed other bits");
	AST_RESETVAL: assert property (@(posedge i_clk)
		!i_rst_n |-> latch_reg == '0 && dir_reg == '0)
		else $error("latch or direction not zero in reset");
endmodule // gpio_port

// [src/gpio_port_pkg.sv]
// Package with register map, field layout and reset values for the general-purpose I/O port
package gpio_port_pkg;
	// ----------------------------------------------------------------
	// Register selection, one select code per register
	// ----------------------------------------------------------------
	localparam int PORT_WIDTH = 8;
	localparam logic [1:0] SEL_OUTPUT_LATCH = 2'h0;
	localparam logic [1:0] SEL_DIRECTION = 2'h1;
	localparam logic [1:0] SEL_PIN_SAMPLE = 2'h2;
	localparam logic [1:0] SEL_CORE_CONTROL = 2'h3;
	// ----------------------------------------------------------------
	// Field positions and reset values
	// ----------------------------------------------------------------
	localparam int PULLUP_DISABLE_BIT = 4;
	localparam logic [7:0] OUTPUT_LATCH_RESET = 8'h00;
	localparam logic [7:0] DIRECTION_RESET = 8'h00;
	localparam logic [7:0] PIN_SAMPLE_RESET = 8'h00;
	localparam logic PULLUP_DISABLE_RESET = 1'b0;
	// ----------------------------------------------------------------
	// Operation codes for whole write, single-bit set and clear, and no operation
	// ----------------------------------------------------------------
	typedef enum logic [1:0] {OP_WRITE, OP_SET_BIT, OP_CLEAR_BIT, OP_NONE} reg_op_t;
	// Register access request carried as one bundle
	typedef struct packed {
		logic valid;
		reg_op_t op;
		logic [1:0] sel;
		logic [2:0] bit_idx;
		logic [7:0] wdata;
	} reg_req_t;
endpackage

// [src/gpio_sync.sv]
// Input synchroniser: clock-high transparent latch followed by a rising-edge register
`timescale 1ns/1ps
module gpio_sync
	import gpio_port_pkg::*;
#(
	parameter int WIDTH = 8
)
(
	// Clock, enable and reset
	input wire logic i_clk,
	input wire logic i_ce,
	input wire logic i_rst_n,
	// Raw pins and synchronised sample
	input wire logic [WIDTH-1:0] i_pins,
	output logic [WIDTH-1:0] o_sample
);
	logic [WIDTH-1:0] latch_reg;
	logic [WIDTH-1:0] sample_reg;
	logic [WIDTH-1:0] sample_next;
	// Latch opens while clock is high, holds on the low phase
	always_latch
	begin
		if (!i_rst_n)
			latch_reg <= PIN_SAMPLE_RESET;
		else if (i_clk && i_ce)
			latch_reg <= i_pins;
	end
	// Second stage reads the latch, or holds its own value while enable is low
	always_comb
	begin
		sample_next = i_ce ? latch_reg : sample_reg;
	end
	always_ff @(posedge i_clk or negedge i_rst_n)
	begin
		if (!i_rst_n)
			sample_reg <= PIN_SAMPLE_RESET;
		else
			sample_reg <= sample_next;
	end
	assign o_sample = sample_reg;
endmodule // gpio_sync

// [bench/gpio_pin_model.sv]
// Behavioural model of the pins and of whatever hangs on them outside the port
`timescale 1ns/1ps
module gpio_pin_model
(
	// Clock and drive from the port
	input wire logic i_clk,
	input wire logic [7:0] i_pin_drv,
	input wire logic [7:0] i_pin_oe,
	input wire logic [7:0] i_pullup_en,
	// Outside driver, set by the bench
	input wire logic [7:0] i_ext_en,
	input wire logic [7:0] i_ext_val,
	// Resolved pin level
	output logic [7:0] o_level
);
	logic [7:0] float_reg = 8'h55;
	// A floating pin wanders every cycle so no check can lean on a stale level
	always @(posedge i_clk)
		float_reg <= ~float_reg;
	// Port drive wins, then the outside driver, then the pull-up
	always_comb
	begin
		o_level = (i_pin_drv & i_pin_oe) | (i_ext_val & i_ext_en & ~i_pin_oe);
		o_level |= i_pullup_en & ~i_pin_oe & ~i_ext_en;
		o_level |= float_reg & ~(i_pin_oe | i_ext_en | i_pullup_en);
	end
endmodule // gpio_pin_model

// [bench/tb_top.sv]
// Self-checking bench for the general-purpose I/O port
`timescale 1ns/1ps
module tb_top;
	import gpio_port_pkg::*;
	logic i_clk;
	logic i_rst_n;
	logic ce;
	reg_req_t req;
	logic [7:0] rdata, pin_drv, pin_oe, pullup_en, level, ext_en, ext_val;
	int err_total;
	int n_compared;
	// ----------------------------------------------------------------
	// Port under test and the pins around it
	// ----------------------------------------------------------------
	gpio_port u_dut (.i_clk(i_clk), .i_ce(ce), .i_rst_n(i_rst_n), .i_req(req),
		.o_rdata(rdata), .i_pin(level), .o_pin(pin_drv), .o_pin_oe(pin_oe),
		.o_pullup_en(pullup_en));
	gpio_pin_model u_pins (.i_clk(i_clk), .i_pin_drv(pin_drv), .i_pin_oe(pin_oe),
		.i_pullup_en(pullup_en), .i_ext_en(ext_en), .i_ext_val(ext_val), .o_level(level));
	// 20 MHz clock
	initial
	begin
		i_clk = 1'b0;
		forever #25 i_clk = ~i_clk;
	end
	// Compare and count
	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		n_compared++;
		if (got !== exp)
		begin
			err_total++;
			$display("BAD %0t got %h want %h", $time, got, exp);
		end
	endtask
	// Write: request held for one taken edge, then dropped at that same edge
	task automatic wr(input reg_op_t op, input logic [1:0] sel, input logic [2:0] idx,
		input logic [7:0] d);
		@(posedge i_clk);
		req <= '{1'b1, op, sel, idx, d};
		@(posedge i_clk);
		req <= '{1'b0, OP_NONE, sel, 3'h0, 8'h00};
		#1;
	endtask
	// Read: select presented at one edge, data settled after the next
	task automatic rd(input logic [1:0] sel, input logic [7:0] exp);
		@(posedge i_clk);
		req <= '{1'b0, OP_NONE, sel, 3'h0, 8'h00};
		@(posedge i_clk);
		#1;
		chk(rdata, exp);
	endtask
	// Verdict and end of run
	task automatic conclude();
		if (err_total == 0 && n_compared > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask
	// ----------------------------------------------------------------
	// Main sequence
	// ----------------------------------------------------------------
	initial
	begin
		req = '0;
		ext_en = 8'h00;
		ext_val = 8'h00;
		ce = 1'b1;
		// Start released so the drop is a real falling edge for the async reset
		i_rst_n = 1'b1;
		err_total = 0;
		n_compared = 0;
		#1 i_rst_n = 1'b0;
		repeat (6) @(posedge i_clk);
		chk(pin_oe | pin_drv | pullup_en, 8'h00);
		i_rst_n <= 1'b1;
		rd(SEL_OUTPUT_LATCH, 8'h00);
		rd(SEL_DIRECTION, 8'h00);
		wr(OP_WRITE, SEL_OUTPUT_LATCH, 3'h0, 8'hA5);
		chk(pullup_en, 8'hA5);
		chk(pin_oe, 8'h00);
		rd(SEL_OUTPUT_LATCH, 8'hA5);
		wr(OP_WRITE, SEL_CORE_CONTROL, 3'h0, 8'h10);
		chk(pullup_en, 8'h00);
		rd(SEL_CORE_CONTROL, 8'h10);
		wr(OP_WRITE, SEL_CORE_CONTROL, 3'h0, 8'h00);
		// Low nibble becomes outputs driving the latch; high-nibble inputs pull up where the latch is one
		wr(OP_WRITE, SEL_DIRECTION, 3'h0, 8'h0F);
		chk(pin_oe, 8'h0F);
		chk(pin_drv & pin_oe, 8'h05);
		chk(pullup_en, 8'hA0);
		@(posedge i_clk);
		ext_en <= 8'hF0;
		ext_val <= 8'h3C;
		repeat (2) @(posedge i_clk);
		rd(SEL_PIN_SAMPLE, 8'h35);
		wr(OP_WRITE, SEL_PIN_SAMPLE, 3'h0, 8'h0F);
		rd(SEL_PIN_SAMPLE, 8'h3A);
		rd(SEL_OUTPUT_LATCH, 8'hAA);
		wr(OP_WRITE, SEL_PIN_SAMPLE, 3'h0, 8'hF0);
		chk(pullup_en, 8'h50);
		wr(OP_SET_BIT, SEL_DIRECTION, 3'h7, 8'h00);
		wr(OP_CLEAR_BIT, SEL_DIRECTION, 3'h0, 8'h00);
		wr(OP_NONE, SEL_DIRECTION, 3'h0, 8'hFF);
		rd(SEL_DIRECTION, 8'h8E);
		// Enable low: the write is ignored and every output holds
		@(posedge i_clk);
		ce <= 1'b0;
		wr(OP_WRITE, SEL_OUTPUT_LATCH, 3'h0, 8'hFF);
		chk(pullup_en, 8'h50);
		@(posedge i_clk);
		ce <= 1'b1;
		rd(SEL_OUTPUT_LATCH, 8'h5A);
		// Reset lands mid-cycle and must float the pins without an edge
		@(posedge i_clk);
		#10 i_rst_n = 1'b0;
		#1 chk(pin_oe | pin_drv | pullup_en, 8'h00);
		@(posedge i_clk);
		i_rst_n <= 1'b1;
		rd(SEL_DIRECTION, 8'h00);
		conclude();
	end
	// Watchdog: the sequence needs well under a hundred cycles
	initial
	begin
		#(2000 * 50);
		err_total++;
		conclude();
	end
endmodule // tb_top
